// File: common/gpio_pkg.sv
package gpio_pkg;
   // Reset values of the port and configuration registers.
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] OTYPE_RST = 8'h00;
   localparam logic [7:0] PULL_RST = 8'hFF;
   localparam logic [3:0] LOCK_RST = 4'h0;
   localparam logic POL_RST = 1'b0;
   localparam logic ROUTE_RST = 1'b0;
   localparam logic [7:0] CFG_RST = 8'h00;

   // Register index of each port register inside its group of four.
   localparam logic [1:0] SUB_DATA = 2'h0;
   localparam logic [1:0] SUB_DIR = 2'h1;
   localparam logic [1:0] SUB_OTYPE = 2'h2;
   localparam logic [1:0] SUB_PULL = 2'h3;
   // Window indices of the bank 1 port 1 extras; byte address is 4x index.
   localparam logic [2:0] IDX_LOCK = 3'h0;
   localparam logic [2:0] IDX_POL = 3'h1;
   localparam logic [2:0] IDX_ROUTE = 3'h2;

   // Byte addresses of the configuration registers.
   localparam logic [15:0] CFG_ACTIVATE = 16'h8000;
   localparam logic [15:0] CFG_FUNC_EN2 = 16'h8004;
   localparam logic [15:0] CFG_BASE_LO = 16'h8008;
   localparam logic [15:0] CFG_BASE_HI = 16'h800C;
   localparam logic [15:0] CFG_GLOBAL1 = 16'h8010;
   localparam logic [15:0] CFG_GLOBAL2 = 16'h8014;
   localparam logic [15:0] CFG_GLOBAL3 = 16'h8018;
   localparam logic [15:0] CFG_PWR3 = 16'h801C;
   localparam logic [15:0] CFG_PWR5 = 16'h8020;
   localparam int CFG_REGION_BIT = 15;
   localparam int WIN_ALIGN_BIT = 5;

   // Field positions.
   localparam int ACT_BIT = 0;
   localparam int FUNCTION_ENABLE_SECOND_GPIO_BIT = 7;
   localparam int G2_BANK_BIT = 7;
   localparam int G1_P2_BIT = 4;
   localparam int G1_P3_BIT = 3;
   localparam int G3_P25_BIT = 0;
   localparam int PW3_P16_BIT = 0;
   localparam int PW3_P15_BIT = 1;
   localparam int PW3_P24_BIT = 3;
   localparam int PW3_P37_BIT = 4;
   localparam int PW5_P33_BIT = 6;
   localparam int LOCK_LSB = 4;
endpackage

// File: hw/gpio_ports_with_pin_routing.sv
// Operation
// - Ports 1, 2 enabled by activate register and function enable two bit 7.
// - Port window decoded at base held in two software base registers.
// - Two register banks; bit 7 of global configuration two selects bank.
// - Port 1 at offsets 0-3 in bank 0 and 0-2 in bank 1.
// - Port 2 at offsets 4-7 in bank 0, port 3 at 4-7 in bank 1.
// - Per-bit direction register chooses input or output.
// - Per-bit output type register chooses open-drain or push-pull.
// - Per-bit pull-up register enables the internal pull-up.
// - Port 1 lock bits 7-4 freeze output type and pull-up of pins 7-4.
// - Pin 0 routed to pin 1 when route bit set and data bit 1 clear.
// - Polarity bit 0 sets the active level of port 1 pin 0.
// - Routed: active pin 0 releases open-drain pin 1 or drives push-pull pin 1 high, inactive pin 0 drives it low.
// - Input pins 0, 2, 3 forwarded to power logic; pin 0 to power-on.
// - Reading an output bit returns the latch, not the pin.
// - Writing an input bit only updates the latch until direction is output.
// - Data write latches reset to all ones.
// - Port 1 bits 5 and 6 pins owned by power control three bits 1 and 0.
// - Port 2 bit 4 owns its pins by global one bit 4 and power three bit 3.
// - Port 2 bit 4 on both pins drives both, reads infrared pin only.
// - Port 2 bit 5 on two pins; drives both, reads keyboard pin only.
// - Port 3 bits 0-2 and 4-6 owned by global one bit 3.
// - Port 3 bit 3 by power five bit 6, bit 7 by power three bit 4.
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
module gpio_ports_with_pin_routing (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [7:0] p1In,
   output logic [7:0] p1Out,
   output logic [7:0] p1Oe,
   output logic [7:0] p1PullEn,
   output logic [7:0] p1Own,
   input wire logic [7:0] p2In,
   output logic [7:0] p2Out,
   output logic [7:0] p2Oe,
   output logic [7:0] p2PullEn,
   output logic [7:0] p2Own,
   input wire logic [7:0] p3In,
   output logic [7:0] p3Out,
   output logic [7:0] p3Oe,
   output logic [7:0] p3PullEn,
   output logic [7:0] p3Own,
   input wire logic infraredReceiveAltIn,
   output logic infraredReceiveAltOut,
   output logic infraredReceiveAltOe,
   output logic infraredReceiveAltPullEn,
   output logic infraredReceiveAltOwn,
   input wire logic keyboardPortBit6In,
   output logic keyboardPortBit6Out,
   output logic keyboardPortBit6Oe,
   output logic keyboardPortBit6PullEn,
   output logic keyboardPortBit6Own,
   output logic [2:0] powerRequestFwd,
   output logic powerOnControlFwd
);

   logic rstMeta_r;
   logic rstSyncN;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rstMeta_r <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSyncN <= rstMeta_r;
      end
   end

   // Bus slave: writes take no wait state, reads take one.
   logic dWrite_r;
   logic dRead_r;
   logic [15:0] dAddr_r;
   logic dMapped_r;
   logic [31:0] hrdata_r;
   wire accept = hsel && hready && htrans[1];

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         dWrite_r <= 1'b0;
         dRead_r <= 1'b0;
         dAddr_r <= 16'h0000;
         dMapped_r <= 1'b0;
      end else if (dRead_r) begin
         // The read wait state lasts one cycle; the address is held meanwhile.
         dRead_r <= 1'b0;
      end else begin
         dWrite_r <= accept && hwrite;
         dRead_r <= accept && !hwrite;
         dAddr_r <= haddr[15:0];
         dMapped_r <= (haddr[31:16] == 16'h0000) && (haddr[1:0] == 2'b00);
      end
   end

   assign hreadyout = !dRead_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Configuration registers.
   logic [7:0] act_r, function_enable_second_r, baseLo_r, baseHi_r;
   logic [7:0] g1_r, g2_r, g3_r, pw3_r, pw5_r;
   wire [7:0] wData = hwdata[7:0];
   wire cfgHit = dMapped_r && dAddr_r[gpio_pkg::CFG_REGION_BIT];
   wire cfgWr = dWrite_r && cfgHit;
   wire active = act_r[gpio_pkg::ACT_BIT];
   wire [15:0] winBase = {baseHi_r, baseLo_r};
   wire winHit = dMapped_r && active
      && !dAddr_r[gpio_pkg::CFG_REGION_BIT]
      && (dAddr_r[15:gpio_pkg::WIN_ALIGN_BIT]
          == winBase[15:gpio_pkg::WIN_ALIGN_BIT]);
   wire winWr = dWrite_r && winHit;
   wire [2:0] winIdx = dAddr_r[4:2];
   wire bank = g2_r[gpio_pkg::G2_BANK_BIT];

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         act_r <= gpio_pkg::CFG_RST;
         function_enable_second_r <= gpio_pkg::CFG_RST;
         baseLo_r <= gpio_pkg::CFG_RST;
         baseHi_r <= gpio_pkg::CFG_RST;
         g1_r <= gpio_pkg::CFG_RST;
         g2_r <= gpio_pkg::CFG_RST;
         g3_r <= gpio_pkg::CFG_RST;
         pw3_r <= gpio_pkg::CFG_RST;
         pw5_r <= gpio_pkg::CFG_RST;
      end else if (cfgWr) begin
         if (dAddr_r == gpio_pkg::CFG_ACTIVATE) act_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_FUNC_EN2) function_enable_second_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_BASE_LO) baseLo_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_BASE_HI) baseHi_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_GLOBAL1) g1_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_GLOBAL2) g2_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_GLOBAL3) g3_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_PWR3) pw3_r <= wData;
         if (dAddr_r == gpio_pkg::CFG_PWR5) pw5_r <= wData;
      end
   end

   wire [7:0] cfgVal =
      (dAddr_r == gpio_pkg::CFG_ACTIVATE) ? act_r :
      (dAddr_r == gpio_pkg::CFG_FUNC_EN2) ? function_enable_second_r :
      (dAddr_r == gpio_pkg::CFG_BASE_LO) ? baseLo_r :
      (dAddr_r == gpio_pkg::CFG_BASE_HI) ? baseHi_r :
      (dAddr_r == gpio_pkg::CFG_GLOBAL1) ? g1_r :
      (dAddr_r == gpio_pkg::CFG_GLOBAL2) ? g2_r :
      (dAddr_r == gpio_pkg::CFG_GLOBAL3) ? g3_r :
      (dAddr_r == gpio_pkg::CFG_PWR3) ? pw3_r :
      (dAddr_r == gpio_pkg::CFG_PWR5) ? pw5_r : 8'h00;

   // Port p sits in bank 1 only for port 3, and at index 4 and up for 2, 3.
   function automatic logic portHit(input logic bk, input logic [2:0] idx,
                                    input int p, input logic [1:0] sub);
      logic hiHalf;
      hiHalf = (p != 0);
      portHit = (bk == (p == 2)) && (idx == {hiHalf, sub});
   endfunction

   // Port 1 extras in bank 1.
   logic [3:0] lock_r;
   logic pol_r;
   logic route_r;
   wire extraWr = winWr && bank;

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         lock_r <= gpio_pkg::LOCK_RST;
         pol_r <= gpio_pkg::POL_RST;
         route_r <= gpio_pkg::ROUTE_RST;
      end else if (extraWr) begin
         if (winIdx == gpio_pkg::IDX_LOCK)
            lock_r <= lock_r | wData[7:gpio_pkg::LOCK_LSB];
         if (winIdx == gpio_pkg::IDX_POL) pol_r <= wData[0];
         if (winIdx == gpio_pkg::IDX_ROUTE) route_r <= wData[0];
      end
   end

   // Enables and pin ownership.
   wire en12 = active && function_enable_second_r[gpio_pkg::FUNCTION_ENABLE_SECOND_GPIO_BIT];
   wire [2:0] portEn = {active, en12, en12};
   wire p2Main = g1_r[gpio_pkg::G1_P2_BIT];
   wire p3Main = g1_r[gpio_pkg::G1_P3_BIT];
   assign p1Own = {1'b1, pw3_r[gpio_pkg::PW3_P16_BIT],
                   pw3_r[gpio_pkg::PW3_P15_BIT], 5'h1F};
   assign p2Own = {2'b11, p2Main, p2Main, 4'hF};
   assign p3Own = {pw3_r[gpio_pkg::PW3_P37_BIT], {3{p3Main}},
                   pw5_r[gpio_pkg::PW5_P33_BIT], {3{p3Main}}};
   assign infraredReceiveAltOwn = pw3_r[gpio_pkg::PW3_P24_BIT];
   assign keyboardPortBit6Own = g3_r[gpio_pkg::G3_P25_BIT];

   logic [7:0] dat_r [3];
   logic [7:0] dir_r [3];
   logic [7:0] otyp_r [3];
   logic [7:0] pull_r [3];
   wire [7:0] pinIn [3];
   wire [7:0] own [3];
   wire [7:0] sense [3];
   wire [7:0] eff [3];
   wire [7:0] oe [3];
   wire [7:0] pu [3];
   wire [7:0] portRd [3];

   assign pinIn[0] = p1In;
   assign pinIn[1] = p2In;
   assign pinIn[2] = p3In;
   assign own[0] = p1Own;
   assign own[1] = p2Own;
   assign own[2] = p3Own;

   // When both pins are owned, port 2 bits 4 and 5 read the alternate pin.
   assign sense[0] = p1In;
   assign sense[1] = {p2In[7:6],
      keyboardPortBit6Own ? keyboardPortBit6In : p2In[5],
      infraredReceiveAltOwn ? infraredReceiveAltIn : p2In[4],
      p2In[3:0]};
   assign sense[2] = p3In;

   // Pin 0 routed onto pin 1 with a selectable active level.
   wire routeOn = route_r && !dat_r[0][1];
   wire pin0Active = pol_r ? p1In[0] : !p1In[0];
   wire routeBit = routeOn ? pin0Active : dat_r[0][1];
   assign eff[0] = {dat_r[0][7:2], routeBit, dat_r[0][0]};
   assign eff[1] = dat_r[1];
   assign eff[2] = dat_r[2];

   wire [7:0] lockMask = {lock_r, 4'h0};

   for (genvar p = 0; p < 3; p++) begin : g_port
      wire [7:0] keep = (p == 0) ? lockMask : 8'h00;
      wire [7:0] keepDat = keep & dir_r[p];
      wire wDat = winWr && portHit(bank, winIdx, p, gpio_pkg::SUB_DATA);
      wire wDir = winWr && portHit(bank, winIdx, p, gpio_pkg::SUB_DIR);
      wire wTyp = winWr && portHit(bank, winIdx, p, gpio_pkg::SUB_OTYPE);
      wire wPul = winWr && portHit(bank, winIdx, p, gpio_pkg::SUB_PULL);
      wire [7:0] rdDat = (dir_r[p] & dat_r[p]) | (~dir_r[p] & sense[p]);

      always_ff @(posedge clk_sys or negedge rstSyncN) begin
         if (!rstSyncN) begin
            dat_r[p] <= gpio_pkg::DATA_RST;
            dir_r[p] <= gpio_pkg::DIR_RST;
            otyp_r[p] <= gpio_pkg::OTYPE_RST;
            pull_r[p] <= gpio_pkg::PULL_RST;
         end else begin
            if (wDat)
               dat_r[p] <= (dat_r[p] & keepDat) | (wData & ~keepDat);
            if (wDir) dir_r[p] <= (dir_r[p] & keep) | (wData & ~keep);
            if (wTyp)
               otyp_r[p] <= (otyp_r[p] & keep) | (wData & ~keep);
            if (wPul)
               pull_r[p] <= (pull_r[p] & keep) | (wData & ~keep);
         end
      end

      // Open-drain drives only a low; push-pull drives both levels.
      assign oe[p] = {8{portEn[p]}} & own[p] & dir_r[p]
                     & (otyp_r[p] | ~eff[p]);
      assign pu[p] = {8{portEn[p]}} & own[p] & pull_r[p];
      assign portRd[p] =
         portHit(bank, winIdx, p, gpio_pkg::SUB_DATA) ? rdDat :
         portHit(bank, winIdx, p, gpio_pkg::SUB_DIR) ? dir_r[p] :
         portHit(bank, winIdx, p, gpio_pkg::SUB_OTYPE) ? otyp_r[p] :
         portHit(bank, winIdx, p, gpio_pkg::SUB_PULL) ? pull_r[p] : 8'h00;
   end

   assign p1Out = eff[0];
   assign p2Out = eff[1];
   assign p3Out = eff[2];
   assign p1Oe = oe[0];
   assign p2Oe = oe[1];
   assign p3Oe = oe[2];
   assign p1PullEn = pu[0];
   assign p2PullEn = pu[1];
   assign p3PullEn = pu[2];

   // Alternate pins follow the same output and pull-up settings.
   wire p2On = portEn[1];
   assign infraredReceiveAltOut = eff[1][4];
   assign infraredReceiveAltOe = p2On && infraredReceiveAltOwn && dir_r[1][4]
      && (otyp_r[1][4] || !eff[1][4]);
   assign infraredReceiveAltPullEn = p2On && infraredReceiveAltOwn
      && pull_r[1][4];
   assign keyboardPortBit6Out = eff[1][5];
   assign keyboardPortBit6Oe = p2On && keyboardPortBit6Own && dir_r[1][5]
      && (otyp_r[1][5] || !eff[1][5]);
   assign keyboardPortBit6PullEn = p2On && keyboardPortBit6Own
      && pull_r[1][5];

   wire [7:0] extraRd = !bank ? 8'h00 :
      (winIdx == gpio_pkg::IDX_LOCK) ? lockMask :
      (winIdx == gpio_pkg::IDX_POL) ? {7'h00, pol_r} :
      (winIdx == gpio_pkg::IDX_ROUTE) ? {7'h00, route_r} : 8'h00;
   wire [7:0] winVal = portRd[0] | portRd[1] | portRd[2] | extraRd;
   wire [7:0] rdVal = cfgHit ? cfgVal : (winHit ? winVal : 8'h00);

   // Forwarding of input pins to the power logic.
   logic [2:0] fwd_r;
   logic onFwd_r;
   wire [2:0] fwdIn = {p1In[3], p1In[2], p1In[0]};
   wire [2:0] fwdDir = {dir_r[0][3], dir_r[0][2], dir_r[0][0]};

   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         hrdata_r <= 32'h0000_0000;
         fwd_r <= 3'b000;
         onFwd_r <= 1'b0;
      end else begin
         if (dRead_r) hrdata_r <= {24'h00_0000, rdVal};
         fwd_r <= fwdIn & ~fwdDir & {3{en12}};
         onFwd_r <= p1In[0] && !dir_r[0][0] && en12;
      end
   end

   assign powerRequestFwd = fwd_r;
   assign powerOnControlFwd = onFwd_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstSyncN);

   property p_lockSticky;
      |($past(lock_r) & ~lock_r) == 1'b0;
   endproperty
   a_lockSticky: assert property (p_lockSticky)
      else $error("Lock bit fell without reset.");

   property p_lockFreeze;
      lock_r[3] |=> $stable(otyp_r[0][7]) && $stable(pull_r[0][7]);
   endproperty
   a_lockFreeze: assert property (p_lockFreeze)
      else $error("Locked pin 7 settings changed.");

   property p_routeLow;
      route_r && !dat_r[0][1] && dir_r[0][1] && en12 && !pol_r && p1In[0]
         |-> p1Oe[1] && !p1Out[1];
   endproperty
   a_routeLow: assert property (p_routeLow)
      else $error("Inactive routed pin did not pull pin 1 low.");

   property p_routeRelease;
      route_r && !dat_r[0][1] && pol_r && p1In[0] && !otyp_r[0][1]
         |-> !p1Oe[1];
   endproperty
   a_routeRelease: assert property (p_routeRelease)
      else $error("Active routed pin did not release pin 1.");

   property p_readLatch;
      dRead_r && winHit && !bank && winIdx == 3'h0 && dir_r[0] == 8'hFF
         |=> hrdata[7:0] == $past(dat_r[0]) && hreadyout;
   endproperty
   a_readLatch: assert property (p_readLatch)
      else $error("Output bit read did not return the latch.");

   property p_inputQuiet;
      !dir_r[2][0] |-> !p3Oe[0];
   endproperty
   a_inputQuiet: assert property (p_inputQuiet)
      else $error("Input pin was driven.");

   property p_disabled;
      !en12 |-> p1Oe == 8'h00 && p2Oe == 8'h00 && p1PullEn == 8'h00;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("Disabled port drives a pin.");

   property p_dualDrive;
      infraredReceiveAltOwn && p2Main && p2Oe[4] |-> infraredReceiveAltOe
         && infraredReceiveAltOut == p2Out[4];
   endproperty
   a_dualDrive: assert property (p_dualDrive)
      else $error("Second pin of port 2 bit 4 not driven.");

   property p_p3Owner;
      !p3Main |-> (p3Oe & 8'h77) == 8'h00 && (p3Own & 8'h77) == 8'h00;
   endproperty
   a_p3Owner: assert property (p_p3Owner)
      else $error("Port 3 pin used while not owned.");

   property p_fwdInput;
      dir_r[0][0] |=> !powerOnControlFwd;
   endproperty
   a_fwdInput: assert property (p_fwdInput)
      else $error("Output pin forwarded to power-on control.");

   c_routeActive: cover property (routeOn && en12 && dir_r[0][1]);
   c_lockSet: cover property ($rose(lock_r[0]));
   c_readPort3: cover property (dRead_r && winHit && bank && winIdx[2]);
   c_dualPin: cover property (infraredReceiveAltOwn && p2Main && p2Oe[4]);

endmodule // gpio_ports_with_pin_routing

// File: verification/pin_model.sv
`timescale 1ns/1ns
module pin_model #(
   parameter int W = 8
) (
   input wire logic clk_sys,
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] drvEn,
   input wire logic [W-1:0] pullEn,
   input wire logic [W-1:0] extVal,
   input wire logic [W-1:0] extEn,
   output logic [W-1:0] level
);
   // A line that nobody drives or pulls changes every cycle, so a floating
   // pin never passes for a steady level.
   logic [W-1:0] toggle_r;
   initial toggle_r = '0;
   always @(posedge clk_sys) begin
      toggle_r <= ~toggle_r;
   end
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (drvEn[i]) begin
            level[i] = drv[i];
         end else if (extEn[i]) begin
            level[i] = extVal[i];
         end else if (pullEn[i]) begin
            level[i] = 1'b1;
         end else begin
            level[i] = toggle_r[i];
         end
      end
   end
endmodule // pin_model

// File: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic hready;
   logic hreadyout, hresp;
   logic [31:0] hrdata;
   logic [7:0] p1In, p1Out, p1Oe, p1PullEn, p1Own;
   logic [7:0] p2In, p2Out, p2Oe, p2PullEn, p2Own;
   logic [7:0] p3In, p3Out, p3Oe, p3PullEn, p3Own;
   logic infraredReceiveAltIn, infraredReceiveAltOut, infraredReceiveAltOe;
   logic infraredReceiveAltPullEn, infraredReceiveAltOwn;
   logic keyboardPortBit6In, keyboardPortBit6Out, keyboardPortBit6Oe;
   logic keyboardPortBit6PullEn, keyboardPortBit6Own;
   logic [2:0] powerRequestFwd;
   logic powerOnControlFwd;
   logic [7:0] x1Val = 8'h00, x1En = 8'h00, x2Val = 8'h00, x2En = 8'h00;
   logic xIrVal = 1'b0, xIrEn = 1'b0, xKbVal = 1'b0, xKbEn = 1'b0;
   logic [7:0] x3Val = 8'h00, x3En = 8'h00;
   int errCount = 0;
   int checks = 0;

   assign hready = hreadyout;
   always #4 clk_sys = ~clk_sys;

   gpio_ports_with_pin_routing u_dut (.clk_sys, .rstn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
      .hresp, .p1In, .p1Out, .p1Oe, .p1PullEn, .p1Own, .p2In, .p2Out,
      .p2Oe, .p2PullEn, .p2Own, .p3In, .p3Out, .p3Oe, .p3PullEn, .p3Own,
      .infraredReceiveAltIn, .infraredReceiveAltOut, .infraredReceiveAltOe,
      .infraredReceiveAltPullEn, .infraredReceiveAltOwn,
      .keyboardPortBit6In, .keyboardPortBit6Out, .keyboardPortBit6Oe,
      .keyboardPortBit6PullEn, .keyboardPortBit6Own, .powerRequestFwd,
      .powerOnControlFwd);
   pin_model #(.W(8)) u_pin1 (.clk_sys, .drv(p1Out), .drvEn(p1Oe),
      .pullEn(p1PullEn), .extVal(x1Val), .extEn(x1En), .level(p1In));
   pin_model #(.W(8)) u_pin2 (.clk_sys, .drv(p2Out), .drvEn(p2Oe),
      .pullEn(p2PullEn), .extVal(x2Val), .extEn(x2En), .level(p2In));
   pin_model #(.W(8)) u_pin3 (.clk_sys, .drv(p3Out), .drvEn(p3Oe),
      .pullEn(p3PullEn), .extVal(x3Val), .extEn(x3En), .level(p3In));
   pin_model #(.W(1)) u_pinIr (.clk_sys, .drv(infraredReceiveAltOut),
      .drvEn(infraredReceiveAltOe), .pullEn(infraredReceiveAltPullEn),
      .extVal(xIrVal), .extEn(xIrEn), .level(infraredReceiveAltIn));
   pin_model #(.W(1)) u_pinKb (.clk_sys, .drv(keyboardPortBit6Out),
      .drvEn(keyboardPortBit6Oe), .pullEn(keyboardPortBit6PullEn),
      .extVal(xKbVal), .extEn(xKbEn), .level(keyboardPortBit6In));

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] e);
      checks++;
      if (got !== e) begin
         errCount++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask

   task automatic waitRdy();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         errCount++;
         $display("Error at %0t: bus wait ran out", $time);
         complete_run();
      end
   endtask

   task automatic bus(input logic wr, input logic [15:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {16'h0000, a};
      hwrite <= wr;
      hsize <= 3'h2;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      waitRdy();
      rd = hrdata[7:0];
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] unused;
      bus(1'b1, a, d, unused);
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] got;
      bus(1'b0, a, 8'h00, got);
      chk(got, e);
   endtask

   // Window base is 16'h0040; register index i sits at base plus 4*i.
   function automatic logic [15:0] w(input int i);
      return 16'h0040 + 16'(4 * i);
   endfunction

   task automatic bank(input logic b);
      wr(gpio_pkg::CFG_GLOBAL2, {b, 7'h00});
   endtask

   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic tEnable();
      wr(gpio_pkg::CFG_BASE_LO, 8'h40);
      wr(gpio_pkg::CFG_BASE_HI, 8'h00);
      wr(gpio_pkg::CFG_ACTIVATE, 8'h01);
      wr(gpio_pkg::CFG_FUNC_EN2, 8'h80);
      rdc(w(1), 8'h00);
      rdc(w(2), 8'h00);
      rdc(w(3), 8'hFF);
      rdc(16'h0060, 8'h00);
      wr(gpio_pkg::CFG_BASE_LO, 8'h80);
      rdc(16'h008C, 8'hFF);
      rdc(16'h004C, 8'h00);
      wr(gpio_pkg::CFG_BASE_LO, 8'h40);
   endtask

   task automatic tOwn();
      logic [7:0] own;
      wr(gpio_pkg::CFG_PWR3, 8'h1B);
      wr(gpio_pkg::CFG_GLOBAL1, 8'h18);
      wr(gpio_pkg::CFG_GLOBAL3, 8'h01);
      wr(gpio_pkg::CFG_PWR5, 8'h40);
      settle();
      own = {p1Own[6:5], p2Own[5:4], infraredReceiveAltOwn,
             keyboardPortBit6Own, 2'b00};
      chk(own, 8'hFC);
      chk(p3Own, 8'hFF);
      wr(gpio_pkg::CFG_PWR3, 8'h01);
      wr(gpio_pkg::CFG_GLOBAL1, 8'h10);
      settle();
      own = {p1Own[6:5], p2Own[5:4], infraredReceiveAltOwn,
             keyboardPortBit6Own, 2'b00};
      chk(own, 8'hB4);
      chk(p3Own, 8'h08);
      wr(gpio_pkg::CFG_PWR3, 8'h1B);
      wr(gpio_pkg::CFG_GLOBAL1, 8'h18);
   endtask

   task automatic tBank();
      wr(w(5), 8'h0F);
      bank(1'b1);
      wr(w(5), 8'h3C);
      rdc(w(5), 8'h3C);
      x3En <= 8'hFF;
      x3Val <= 8'hA5;
      wr(w(4), 8'h00);
      settle();
      chk(p3Oe, 8'h3C);
      chk(p3Out, 8'h00);
      rdc(w(4), 8'h81);
      rdc(w(3), 8'h00);
      bank(1'b0);
      rdc(w(5), 8'h0F);
   endtask

   task automatic tDir();
      x1En <= 8'hFF;
      x1Val <= 8'h3C;
      wr(w(0), 8'hA5);
      settle();
      chk(p1Oe, 8'h00);
      rdc(w(0), 8'h3C);
      wr(w(1), 8'hFF);
      settle();
      chk(p1Oe, 8'h5A);
      rdc(w(0), 8'hA5);
      wr(w(2), 8'hFF);
      settle();
      chk(p1Oe, 8'hFF);
      chk(p1Out, 8'hA5);
      wr(w(3), 8'h0F);
      settle();
      chk(p1PullEn, 8'h0F);
   endtask

   task automatic tRoute();
      bank(1'b1);
      wr(w(gpio_pkg::IDX_POL), 8'h01);
      wr(w(gpio_pkg::IDX_ROUTE), 8'h01);
      bank(1'b0);
      wr(w(2), 8'h00);
      wr(w(1), 8'h02);
      wr(w(0), 8'hFD);
      x1En <= 8'h01;
      x1Val <= 8'h00;
      settle();
      chk({6'h00, p1Oe[1], p1Out[1]}, 8'h02);
      x1Val <= 8'h01;
      settle();
      chk({7'h00, p1Oe[1]}, 8'h00);
      bank(1'b1);
      wr(w(gpio_pkg::IDX_POL), 8'h00);
      bank(1'b0);
      settle();
      chk({6'h00, p1Oe[1], p1Out[1]}, 8'h02);
      wr(w(0), 8'hFF);
      settle();
      chk({6'h00, p1Oe[1], p1Out[1]}, 8'h01);
   endtask

   task automatic tFwd();
      x1En <= 8'h0D;
      x1Val <= 8'h0D;
      settle();
      settle();
      chk({5'h00, powerRequestFwd}, 8'h07);
      chk({7'h00, powerOnControlFwd}, 8'h01);
      x1Val <= 8'h04;
      settle();
      settle();
      chk({5'h00, powerRequestFwd}, 8'h02);
      chk({7'h00, powerOnControlFwd}, 8'h00);
      wr(w(1), 8'h03);
      x1Val <= 8'h0D;
      settle();
      settle();
      chk({5'h00, powerRequestFwd}, 8'h06);
   endtask

   task automatic tAlt();
      wr(w(6), 8'h30);
      wr(w(4), 8'h10);
      wr(w(5), 8'h30);
      settle();
      chk({4'h0, infraredReceiveAltOut, p2Out[4], keyboardPortBit6Out,
           p2Out[5]}, 8'h0C);
      chk({2'b00, infraredReceiveAltPullEn, keyboardPortBit6PullEn,
           infraredReceiveAltOe, keyboardPortBit6Oe, p2Oe[5:4]},
          8'h3F);
      wr(w(5), 8'h00);
      x2En <= 8'h30;
      x2Val <= 8'h00;
      xIrEn <= 1'b1;
      xIrVal <= 1'b1;
      xKbEn <= 1'b1;
      xKbVal <= 1'b1;
      rdc(w(4), 8'hFF);
      xIrVal <= 1'b0;
      rdc(w(4), 8'hEF);
   endtask

   task automatic tActive();
      wr(gpio_pkg::CFG_FUNC_EN2, 8'h00);
      settle();
      chk(p1PullEn, 8'h00);
      chk(p2PullEn, 8'h00);
      chk(p3PullEn, 8'hFF);
      wr(gpio_pkg::CFG_FUNC_EN2, 8'h80);
      settle();
      chk(p2PullEn, 8'hFF);
   endtask

   task automatic tLock();
      bank(1'b1);
      wr(w(gpio_pkg::IDX_LOCK), 8'hF0);
      bank(1'b0);
      wr(w(2), 8'hFF);
      rdc(w(2), 8'h0F);
      wr(w(3), 8'hF0);
      rdc(w(3), 8'h00);
      bank(1'b1);
      wr(w(gpio_pkg::IDX_LOCK), 8'h00);
      rdc(w(gpio_pkg::IDX_LOCK), 8'hF0);
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      chk(p1Out, 8'hFF);
      chk(p1Oe, 8'h00);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      tEnable();
      tOwn();
      tBank();
      tDir();
      tRoute();
      tFwd();
      tAlt();
      tActive();
      tLock();
      complete_run();
   end
endmodule // tb_top
